// ==== include/sivc_pkg.sv ====
// Package with constants and types for the system interrupt vector control block.
package sivc_pkg;

  localparam int          SIVC_DATA_W      = 16;
  localparam int          SIVC_ADDR_W      = 20;
  localparam logic [15:0] SIVC_VACANT_DATA = 16'h3FFF;
  localparam logic [19:0] SIVC_BOOT_VECTOR = 20'h01BFE;
  localparam int          SIVC_ACCEPT_CYC  = 6;
  localparam int          SIVC_RETURN_CYC  = 5;
  localparam logic [15:0] SIVC_NO_SOURCE   = 16'h0000;
  localparam logic [15:0] SIVC_CODE_STEP   = 16'h0002;

  // Status register bit positions.
  localparam int          SIVC_SR_GIE      = 3;
  localparam logic [15:0] SIVC_SR_RESET    = 16'h0000;

  // Source positions inside the user-level group.
  localparam int          SIVC_U_PIN       = 0;
  localparam int          SIVC_U_OSC       = 1;
  localparam int          SIVC_U_ACCV      = 2;
  localparam int          SIVC_U_N         = 3;

  // Source positions inside the system-level group.
  localparam int          SIVC_S_LOW_SIDE_SUPERVISOR      = 0;
  localparam int          SIVC_S_HIGH_SIDE_SUPERVISOR      = 1;
  localparam int          SIVC_S_PMTO      = 2;
  localparam int          SIVC_S_VACANT    = 3;
  localparam int          SIVC_S_MBOX      = 4;
  localparam int          SIVC_S_N         = 5;

  localparam int          SIVC_R_N         = 4;

  // Processor-side sequencer states.
  typedef enum logic [2:0] {
    SIVC_RUN,
    SIVC_ACCEPT,
    SIVC_HANDLER,
    SIVC_RETURN,
    SIVC_ONE_INSTR
  } sivc_seq_type;

  // Kind of interrupt being accepted.
  typedef enum logic [1:0] {
    SIVC_K_NONE,
    SIVC_K_SYS,
    SIVC_K_USER,
    SIVC_K_MASK
  } sivc_kind_type;

endpackage

// ==== include/sivc_vec_if.sv ====
// Interface joining the top block and one vector group.
`timescale 1ns/100ps
interface sivc_vec_if #(parameter int N = 4);
  logic [N-1:0] events;
  logic [N-1:0] enables;
  logic         readStb;
  logic         writeStb;
  logic [15:0]  vector;
  logic         pending;
  modport group (input events, input enables, input readStb, input writeStb,
                 output vector, output pending);
  modport top (output events, output enables, output readStb, output writeStb,
               input vector, input pending);
endinterface

// ==== core/sivc_vector_group.sv ====
// One priority-encoded vector register with sticky flags and its clearing.
`timescale 1ns/100ps
module sivc_vector_group
  import sivc_pkg::*;
#(
  parameter int N = 4
) (
  input  wire logic clock,
  input  wire logic arst_n,
  sivc_vec_if.group port
);

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;
  logic [15:0]  vector_reg;
  logic [15:0]  vector_next;
  logic [N-1:0] shownBit;

  // A read clears the flag the register shows now, never a newer one.
  // The code is then encoded from the updated flags, so the register
  // never lags the flags; lowest index is highest priority.
  always_comb begin
    shownBit = '0;
    for (int i = 0; i < N; i++) begin
      if (vector_reg == 16'((i + 1) * 2)) begin
        shownBit[i] = 1'b1;
      end
    end
    flag_next = flag_reg;
    if (port.writeStb) begin
      flag_next = '0;
    end else if (port.readStb) begin
      flag_next = flag_reg & ~shownBit;
    end
    flag_next = flag_next | port.events;
    vector_next = SIVC_NO_SOURCE;
    for (int i = N - 1; i >= 0; i--) begin
      if (flag_next[i] && port.enables[i]) begin
        vector_next = 16'((i + 1) * 2);
      end
    end
  end

  // Registers flags and the presented vector.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg   <= '0;
      vector_reg <= SIVC_NO_SOURCE;
    end else begin
      flag_reg   <= flag_next;
      vector_reg <= vector_next;
    end
  end

  assign port.vector  = vector_reg;
  assign port.pending = (vector_reg != SIVC_NO_SOURCE);

endmodule

// ==== core/sivc_top.sv ====
// System interrupt vector control: vacant decode, event groups and sequencing.
// Notes on behaviour
// - Vacant region access raises system event.
// - Vacant reads return 3FFF jump-to-self.
// - Peripheral-space fetch forces power-up clear.
// - Finished boot region behaves as vacant.
// - Brownout start vector is boot location.
// - Three vector registers, one per group.
// - Vector shows highest enabled pending source.
// - Zero means none; codes step by two.
// - Vector read clears only reported flag.
// - Remaining flags request again after service.
// - Vector write clears whole group.
// - Fixed priority by chain position.
// - Events ignore global enable; own enables.
// - Accepted user event disables further ones.
// - User sources: pin edge, oscillator, access.
// - System sources: supervisors, timeout, vacant, mailbox.
// - Storm: one instruction between system handlers.
// - Maskable needs own and global enable.
// - Acceptance takes six cycles, then vector.
// - Acceptance clears single-source flags only.
// - Return takes five cycles, restores status.
// - Global enable in handler allows preemption.
`timescale 1ns/100ps
module sivc_top
  import sivc_pkg::*;
#(
  parameter int          NMASK      = 8,
  parameter logic [19:0] VAC_LO     = 20'h45C00,
  parameter logic [19:0] PERIPH_LO  = 20'h00100,
  parameter logic [19:0] PERIPH_HI  = 20'h00FEF,
  parameter logic [19:0] BOOT_LO    = 20'h01000,
  parameter logic [19:0] BOOT_HI    = 20'h017FF,
  parameter logic [NMASK-1:0] SINGLE_SRC = '1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             brownoutReset,
  input  wire logic             bootDone,
  input  wire logic             accValid,
  input  wire logic [1:0]       accKind,
  input  wire logic [19:0]      accAddr,
  output logic [15:0]           vacantData,
  output logic                  vacantHit,
  output logic                  powerUpClear,
  output logic [19:0]           resetVectorAddr,
  input  wire logic             nmiPinMode,
  input  wire logic             nmiPin,
  input  wire logic             oscFault,
  input  wire logic             flashAccViol,
  input  wire logic             pinEventEnable,
  input  wire logic             accessViolationEnable,
  input  wire logic             oscillatorFaultEnable,
  input  wire logic             lowSideSupervisor,
  input  wire logic             highSideSupervisor,
  input  wire logic             powerManagementTimeout,
  input  wire logic             debugMailbox,
  input  wire logic [4:0]       sysEnable,
  input  wire logic [3:0]       resetCauseSet,
  input  wire logic [1:0]       vecSelect,
  input  wire logic             vecRead,
  input  wire logic             vecWrite,
  output logic [15:0]           vecReadData,
  input  wire logic [NMASK-1:0] maskReq,
  input  wire logic [NMASK-1:0] maskEnable,
  output logic [NMASK-1:0]      maskAck,
  input  wire logic             instrDone,
  input  wire logic             retiIssue,
  input  wire logic             statusWrite,
  input  wire logic [15:0]      statusWriteData,
  output logic [15:0]           statusRegister,
  output logic                  cpuStall,
  output logic                  vectorLoad,
  output logic [1:0]            vectorKind,
  output logic [3:0]            vectorIndex,
  output logic                  userLevelEventArmed
);

  sivc_vec_if #(.N(SIVC_U_N)) uIf ();
  sivc_vec_if #(.N(SIVC_S_N)) sIf ();
  sivc_vec_if #(.N(SIVC_R_N)) rIf ();

  sivc_seq_type  seq_reg,   seq_next;
  sivc_kind_type kind_reg,  kind_next;
  logic [2:0]    cnt_reg,   cnt_next;
  logic [15:0]   sr_reg,    sr_next;
  logic [15:0]   saved_reg, saved_next;
  logic          uArm_reg,  uArm_next;
  logic          pin_reg;
  logic          nest_reg,  nest_next;
  logic [3:0]    idx_reg,   idx_next;
  logic [NMASK-1:0] ack_reg, ack_next;
  logic          vload_reg, vload_next;
  logic [15:0]   vdat_reg,  vdat_next;
  logic          vhit_reg,  vhit_next;
  logic          puc_reg,   puc_next;
  logic [15:0]   rd_reg,    rd_next;
  logic [19:0]   rv_reg;
  logic          stall_reg, stall_next;
  logic          isVacant;
  logic          isPeriph;
  logic [NMASK-1:0] maskLive;
  logic          maskAny;
  logic [3:0]    maskIdx;
  logic          pinEdge;

  // Address decode for vacant space, including the retired boot area.
  always_comb begin
    isPeriph = (accAddr >= PERIPH_LO) && (accAddr <= PERIPH_HI);
    isVacant = (accAddr >= VAC_LO)
      || (bootDone && accAddr >= BOOT_LO && accAddr <= BOOT_HI);
    vhit_next = accValid && isVacant;
    vdat_next = (accValid && isVacant && accKind != 2'd1) ? SIVC_VACANT_DATA
      : 16'h0000;
    puc_next  = accValid && accKind == 2'd2 && isPeriph;
  end

  // Event sources per group; pin edge only in event mode.
  assign pinEdge = nmiPinMode && nmiPin && !pin_reg;
  assign uIf.events   = {flashAccViol, oscFault, pinEdge};
  assign uIf.enables  = {accessViolationEnable, oscillatorFaultEnable, pinEventEnable};
  assign sIf.events   = {debugMailbox, vhit_reg, powerManagementTimeout,
                         highSideSupervisor, lowSideSupervisor};
  assign sIf.enables  = sysEnable;
  assign rIf.events   = resetCauseSet;
  assign rIf.enables  = '1;
  assign uIf.readStb  = vecRead && vecSelect == 2'd2;
  assign sIf.readStb  = vecRead && vecSelect == 2'd1;
  assign rIf.readStb  = vecRead && vecSelect == 2'd0;
  assign uIf.writeStb = vecWrite && vecSelect == 2'd2;
  assign sIf.writeStb = vecWrite && vecSelect == 2'd1;
  assign rIf.writeStb = vecWrite && vecSelect == 2'd0;

  sivc_vector_group #(.N(SIVC_U_N)) uGroup (.clock(clock), .arst_n(arst_n), .port(uIf));
  sivc_vector_group #(.N(SIVC_S_N)) sGroup (.clock(clock), .arst_n(arst_n), .port(sIf));
  sivc_vector_group #(.N(SIVC_R_N)) rGroup (.clock(clock), .arst_n(arst_n), .port(rIf));

  // Maskable requests, lowest index first in the chain.
  always_comb begin
    maskLive = maskReq & maskEnable;
    maskAny  = (|maskLive) && sr_reg[SIVC_SR_GIE];
    maskIdx  = 4'h0;
    for (int i = NMASK - 1; i >= 0; i--) begin
      if (maskLive[i]) begin
        maskIdx = 4'(i);
      end
    end
  end

  // Sequencer mirrors the processor acceptance and return timing.
  always_comb begin
    seq_next   = seq_reg;
    kind_next  = kind_reg;
    cnt_next   = cnt_reg;
    sr_next    = sr_reg;
    saved_next = saved_reg;
    uArm_next  = uArm_reg;
    nest_next  = nest_reg;
    idx_next   = idx_reg;
    ack_next   = '0;
    vload_next = 1'b0;
    rd_next    = rd_reg;
    if (vecRead) begin
      case (vecSelect)
        2'd0:    rd_next = rIf.vector;
        2'd1:    rd_next = sIf.vector;
        2'd2:    rd_next = uIf.vector;
        default: rd_next = SIVC_NO_SOURCE;
      endcase
    end
    if (statusWrite) begin
      sr_next = statusWriteData;
    end
    if (uIf.writeStb || uIf.readStb) begin
      uArm_next = 1'b1;
    end
    case (seq_reg)
      SIVC_RUN, SIVC_HANDLER, SIVC_ONE_INSTR: begin
        if (seq_reg == SIVC_HANDLER && retiIssue) begin
          seq_next = SIVC_RETURN;
          cnt_next = 3'(SIVC_RETURN_CYC - 1);
        end else if (instrDone) begin
          kind_next = SIVC_K_NONE;
          // Storm guard: no new entry in the single instruction slot.
          if (seq_reg == SIVC_ONE_INSTR) begin
            seq_next = SIVC_RUN;
          end else if (sIf.pending && !(seq_reg == SIVC_HANDLER && kind_reg == SIVC_K_SYS
                                          && !sr_reg[SIVC_SR_GIE])) begin
            kind_next = SIVC_K_SYS;
          end else if (uIf.pending && uArm_reg && kind_reg != SIVC_K_SYS) begin
            kind_next = SIVC_K_USER;
            uArm_next = 1'b0;
          end else if (maskAny) begin
            kind_next = SIVC_K_MASK;
            idx_next  = maskIdx;
            ack_next  = (SINGLE_SRC & (NMASK'(1) << maskIdx));
          end
          if (kind_next != SIVC_K_NONE) begin
            seq_next   = SIVC_ACCEPT;
            cnt_next   = 3'(SIVC_ACCEPT_CYC - 1);
            saved_next = sr_reg;
            nest_next  = (seq_reg == SIVC_HANDLER);
          end
        end
      end
      SIVC_ACCEPT: begin
        if (cnt_reg == 3'd1) begin
          sr_next = SIVC_SR_RESET;
        end
        if (cnt_reg == 3'd0) begin
          vload_next = 1'b1;
          seq_next   = SIVC_HANDLER;
        end else begin
          cnt_next = cnt_reg - 3'd1;
        end
      end
      SIVC_RETURN: begin
        if (cnt_reg == 3'(SIVC_RETURN_CYC - 1)) begin
          sr_next = saved_reg;
        end
        if (cnt_reg == 3'd0) begin
          seq_next  = nest_reg ? SIVC_HANDLER
                    : (kind_reg == SIVC_K_SYS ? SIVC_ONE_INSTR : SIVC_RUN);
          nest_next = 1'b0;
          if (!nest_reg && kind_reg != SIVC_K_SYS) begin
            kind_next = SIVC_K_NONE;
          end
        end else begin
          cnt_next = cnt_reg - 3'd1;
        end
      end
      default: begin
        seq_next = SIVC_RUN;
      end
    endcase
    // Stall is registered from the next state so the port comes from a flop.
    stall_next = (seq_next == SIVC_ACCEPT) || (seq_next == SIVC_RETURN);
  end

  // Registers sequencer, status and decode outputs.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seq_reg   <= SIVC_RUN;
      kind_reg  <= SIVC_K_NONE;
      cnt_reg   <= 3'h0;
      sr_reg    <= SIVC_SR_RESET;
      saved_reg <= SIVC_SR_RESET;
      uArm_reg  <= 1'b1;
      pin_reg   <= 1'b1; // Avoids a false edge if the pin idles high.
      nest_reg  <= 1'b0;
      idx_reg   <= 4'h0;
      ack_reg   <= '0;
      vload_reg <= 1'b0;
      vdat_reg  <= 16'h0000;
      vhit_reg  <= 1'b0;
      puc_reg   <= 1'b0;
      rd_reg    <= SIVC_NO_SOURCE;
      rv_reg    <= 20'h00000;
      stall_reg <= 1'b0;
    end else begin
      seq_reg   <= seq_next;
      kind_reg  <= kind_next;
      cnt_reg   <= cnt_next;
      sr_reg    <= sr_next;
      saved_reg <= saved_next;
      uArm_reg  <= uArm_next;
      pin_reg   <= nmiPin;
      nest_reg  <= nest_next;
      idx_reg   <= idx_next;
      ack_reg   <= ack_next;
      vload_reg <= vload_next;
      vdat_reg  <= vdat_next;
      vhit_reg  <= vhit_next;
      puc_reg   <= puc_next;
      rd_reg    <= rd_next;
      stall_reg <= stall_next;
      if (brownoutReset) begin
        rv_reg <= SIVC_BOOT_VECTOR;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign vacantData          = vdat_reg;
  assign vacantHit           = vhit_reg;
  assign powerUpClear        = puc_reg;
  assign resetVectorAddr     = rv_reg;
  assign vecReadData         = rd_reg;
  assign maskAck             = ack_reg;
  assign statusRegister      = sr_reg;
  assign cpuStall            = stall_reg;
  assign vectorLoad          = vload_reg;
  assign vectorKind          = kind_reg;
  assign vectorIndex         = idx_reg;
  assign userLevelEventArmed = uArm_reg;

endmodule

// ==== dv/sivc_cpu_model.sv ====
// Behavioural processor core that retires instructions and runs short handlers.
`timescale 1ns/100ps
module sivc_cpu_model (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic run,
  input  wire logic slow,
  input  wire logic cpuStall,
  input  wire logic vectorLoad,
  output logic      instrDone,
  output logic      retiIssue
);
  logic [1:0] gap_reg;
  logic [2:0] hcnt_reg;
  logic       inIsr_reg;

  // Retires one instruction every second or fourth cycle, issues the return six cycles after the vector load.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg   <= 2'h0;
      hcnt_reg  <= 3'h0;
      inIsr_reg <= 1'b0;
      instrDone <= 1'b0;
      retiIssue <= 1'b0;
    end else begin
      gap_reg   <= gap_reg + 2'h1;
      instrDone <= run && !cpuStall && !instrDone && (!slow || gap_reg == 2'h0);
      retiIssue <= inIsr_reg && hcnt_reg == 3'h4;
      if (vectorLoad) begin
        inIsr_reg <= 1'b1;
        hcnt_reg  <= 3'h0;
      end else if (retiIssue) begin
        inIsr_reg <= 1'b0;
      end else if (inIsr_reg) begin
        hcnt_reg  <= hcnt_reg + 3'h1;
      end
    end
  end
endmodule

// ==== dv/sivc_chk.sv ====
// Concurrent checks on the ports of the interrupt vector control top.
`timescale 1ns/100ps
module sivc_chk
  import sivc_pkg::*;
#(
  parameter logic [19:0] VAC_LO    = 20'h45C00,
  parameter logic [19:0] PERIPH_LO = 20'h00100,
  parameter logic [19:0] PERIPH_HI = 20'h00FEF,
  parameter logic [19:0] BOOT_LO   = 20'h01000,
  parameter logic [19:0] BOOT_HI   = 20'h017FF
) (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        brownoutReset,
  input wire logic        bootDone,
  input wire logic        accValid,
  input wire logic [1:0]  accKind,
  input wire logic [19:0] accAddr,
  input wire logic [15:0] vacantData,
  input wire logic        vacantHit,
  input wire logic        powerUpClear,
  input wire logic [19:0] resetVectorAddr,
  input wire logic        vecRead,
  input wire logic [15:0] vecReadData,
  input wire logic        retiIssue,
  input wire logic [15:0] statusRegister,
  input wire logic        cpuStall,
  input wire logic        vectorLoad,
  input wire logic [1:0]  vectorKind,
  input wire logic        userLevelEventArmed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Accesses into the vacant range are flagged and reads return the fixed word.
  a_vacant_read: assert property (accValid && accKind != 2'h1 && accAddr >= VAC_LO
    |=> vacantHit && vacantData == SIVC_VACANT_DATA) else $error("vacant read wrong");
  a_vacant_hit: assert property (accValid && accAddr >= VAC_LO |=> vacantHit)
    else $error("vacant access not flagged");
  a_periph_fetch: assert property (accValid && accKind == 2'h2 && accAddr >= PERIPH_LO
    && accAddr <= PERIPH_HI |=> powerUpClear) else $error("peripheral fetch no clear");
  a_boot_vacant: assert property (accValid && bootDone && accAddr >= BOOT_LO
    && accAddr <= BOOT_HI |=> vacantHit) else $error("finished boot area not vacant");
  a_brownout_vector: assert property (brownoutReset |=>
    resetVectorAddr == SIVC_BOOT_VECTOR) else $error("brownout vector wrong");
  a_even_code: assert property (vecRead |=> !vecReadData[0])
    else $error("odd vector code");
  a_accept_six: assert property ($rose(cpuStall) && !$past(retiIssue)
    |-> ##6 vectorLoad && statusRegister == SIVC_SR_RESET) else $error("acceptance timing");
  a_mask_gie: assert property (vectorLoad && vectorKind == SIVC_K_MASK
    |-> $past(statusRegister[SIVC_SR_GIE], 6)) else $error("masked taken without enable");
  a_user_disarm: assert property (vectorLoad && vectorKind == SIVC_K_USER
    |-> ##[0:1] !userLevelEventArmed) else $error("user events still armed");
  a_return_ends: assert property ($rose(cpuStall) && $past(retiIssue)
    |-> ##4 cpuStall ##1 !cpuStall) else $error("return length wrong");

  // Main scenarios reached.
  c_sys: cover property (vectorLoad && vectorKind == SIVC_K_SYS);
  c_user: cover property (vectorLoad && vectorKind == SIVC_K_USER);
  c_mask: cover property (vectorLoad && vectorKind == SIVC_K_MASK);
endmodule

bind sivc_top sivc_chk #(.VAC_LO(VAC_LO), .PERIPH_LO(PERIPH_LO), .PERIPH_HI(PERIPH_HI),
  .BOOT_LO(BOOT_LO), .BOOT_HI(BOOT_HI)) u_sivc_chk (.clock, .arst_n, .brownoutReset,
  .bootDone, .accValid, .accKind, .accAddr, .vacantData, .vacantHit, .powerUpClear,
  .resetVectorAddr, .vecRead, .vecReadData, .retiIssue, .statusRegister, .cpuStall,
  .vectorLoad, .vectorKind, .userLevelEventArmed);

// ==== dv/sivc_top_bench.sv ====
// Self-checking bench for the interrupt vector control top.
`timescale 1ns/100ps
module sivc_top_bench;
  import sivc_pkg::*;
  logic clock = 0, arst_n = 0, run, slow, vacantHit, powerUpClear, cpuStall, vectorLoad;
  logic brownoutReset, bootDone, accValid, nmiPinMode, nmiPin, oscFault, flashAccViol;
  logic pinEventEnable, accessViolationEnable, oscillatorFaultEnable, lowSideSupervisor;
  logic highSideSupervisor, powerManagementTimeout, debugMailbox, vecRead, vecWrite;
  logic statusWrite, instrDone, retiIssue, userLevelEventArmed;
  logic [1:0]  accKind, vecSelect, vectorKind;
  logic [19:0] accAddr, resetVectorAddr;
  logic [15:0] vacantData, vecReadData, statusWriteData, statusRegister;
  logic [4:0]  sysEnable;
  logic [3:0]  resetCauseSet, vectorIndex;
  logic [7:0]  maskReq, maskEnable, maskAck, ackSeen;
  int          n_fail, samples_checked, nLoads, i;

  sivc_top u_sivc_top (.clock, .arst_n, .brownoutReset, .bootDone, .accValid, .accKind,
    .accAddr, .vacantData, .vacantHit, .powerUpClear, .resetVectorAddr, .nmiPinMode,
    .nmiPin, .oscFault, .flashAccViol, .pinEventEnable, .accessViolationEnable,
    .oscillatorFaultEnable, .lowSideSupervisor, .highSideSupervisor,
    .powerManagementTimeout, .debugMailbox, .sysEnable, .resetCauseSet, .vecSelect,
    .vecRead, .vecWrite, .vecReadData, .maskReq, .maskEnable, .maskAck, .instrDone,
    .retiIssue, .statusWrite, .statusWriteData, .statusRegister, .cpuStall, .vectorLoad,
    .vectorKind, .vectorIndex, .userLevelEventArmed);
  sivc_cpu_model u_sivc_cpu_model (.clock, .arst_n, .run, .slow, .cpuStall, .vectorLoad,
    .instrDone, .retiIssue);

  // Clock and a count of vector loads.
  always #25 clock = ~clock;
  always @(posedge clock) if (vectorLoad === 1'b1) nLoads++;
  // Keeps the last non-zero acknowledge pulse.
  always @(posedge clock) if (maskAck !== 8'h00) ackSeen = maskAck;

  // Compares one observed value with its expectation.
  task automatic chk(string nm, logic [19:0] seen, logic [19:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One memory access, then settle after the capturing edge.
  task automatic acc(logic [1:0] k, logic [19:0] a);
    @(posedge clock) accValid <= 1'b1; accKind <= k; accAddr <= a;
    @(posedge clock) accValid <= 1'b0;
    #1;
  endtask
  task automatic vread(logic [1:0] s, logic [15:0] exp);
    @(posedge clock) vecSelect <= s; vecRead <= 1'b1;
    @(posedge clock) vecRead <= 1'b0;
    #1 chk("vector", vecReadData, exp);
  endtask
  task automatic vwrite(logic [1:0] s);
    @(posedge clock) vecSelect <= s; vecWrite <= 1'b1;
    @(posedge clock) vecWrite <= 1'b0;
  endtask
  task automatic wait_load(logic [1:0] k);
    for (i = 0; i < 40; i++) begin
      @(posedge clock) #1;
      if (vectorLoad === 1'b1) break;
    end
    chk("kind", vectorKind, k);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 150 cycles of the sequence.
  initial begin
    #(50 * 5000);
    n_fail++;
    end_sim();
  end

  // Main sequence.
  initial begin
    {run, slow, brownoutReset, bootDone, accValid, nmiPin, oscFault, flashAccViol} = '0;
    {lowSideSupervisor, highSideSupervisor, powerManagementTimeout, debugMailbox} = '0;
    {vecRead, vecWrite, statusWrite, accKind, vecSelect, accAddr, maskReq} = '0;
    {nmiPinMode, pinEventEnable, accessViolationEnable, oscillatorFaultEnable} = 4'hF;
    {statusWriteData, resetCauseSet, sysEnable, maskEnable} = {16'h0000, 4'h0, 5'h1F, 8'hFF};
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock) #1 chk("armed", userLevelEventArmed, 1);
    acc(2'h0, 20'h45C00); chk("vdata", vacantData, 16'h3FFF);
    chk("vhit", vacantHit, 1);
    vread(2'h1, 16'h0008);
    acc(2'h2, 20'h00200); chk("puc", powerUpClear, 1);
    acc(2'h0, 20'h01000); chk("bootbusy", vacantHit, 0);
    bootDone <= 1'b1;
    acc(2'h1, 20'h017FF); chk("bootdone", vacantHit, 1);
    vwrite(2'h1);
    vread(2'h1, 16'h0000);
    @(posedge clock) brownoutReset <= 1'b1;
    @(posedge clock) brownoutReset <= 1'b0;
    #1 chk("bootvec", resetVectorAddr, 20'h01BFE);
    $display("test vacant done");
    @(posedge clock) {lowSideSupervisor, highSideSupervisor, debugMailbox} <= 3'h7;
    @(posedge clock) {lowSideSupervisor, highSideSupervisor, debugMailbox} <= 3'h0;
    vread(2'h1, 16'h0002);
    vread(2'h1, 16'h0004);
    vread(2'h1, 16'h000A);
    vread(2'h1, 16'h0000);
    @(posedge clock) {sysEnable, lowSideSupervisor} <= {5'h1E, 1'b1};
    @(posedge clock) lowSideSupervisor <= 1'b0;
    vread(2'h1, 16'h0000);
    vwrite(2'h1);
    @(posedge clock) {sysEnable, resetCauseSet} <= {5'h1F, 4'hA};
    @(posedge clock) resetCauseSet <= 4'h0;
    vread(2'h0, 16'h0004);
    vread(2'h0, 16'h0008);
    vread(2'h0, 16'h0000);
    @(posedge clock) {oscFault, flashAccViol} <= 2'h3;
    @(posedge clock) {oscFault, flashAccViol} <= 2'h0;
    vwrite(2'h2);
    vread(2'h2, 16'h0000);
    @(posedge clock) {vecSelect, vecWrite, oscFault} <= {2'h2, 2'h3};
    @(posedge clock) {vecWrite, oscFault} <= 2'h0;
    vread(2'h2, 16'h0004);
    $display("test vectors done");
    @(posedge clock) {statusWrite, statusWriteData, slow} <= {1'b1, 16'h0008, 1'b1};
    @(posedge clock) {statusWrite, maskReq, run} <= {1'b0, 8'h04, 1'b1};
    wait_load(SIVC_K_MASK);
    chk("sr", statusRegister, 16'h0000);
    chk("index", vectorIndex, 4'h2);
    chk("ack", ackSeen, 8'h04);
    @(posedge clock) maskReq <= 8'h00;
    repeat (16) @(posedge clock);
    #1 chk("srback", statusRegister, 16'h0008);
    @(posedge clock) {statusWrite, statusWriteData, slow} <= {1'b1, 16'h0000, 1'b0};
    @(posedge clock) {statusWrite, maskReq} <= {1'b0, 8'h02};
    i = nLoads;
    repeat (20) @(posedge clock);
    #1 chk("nogie", nLoads, i);
    @(posedge clock) {maskReq, debugMailbox} <= {8'h00, 1'b1};
    @(posedge clock) debugMailbox <= 1'b0;
    wait_load(SIVC_K_SYS);
    vread(2'h1, 16'h000A);
    repeat (12) @(posedge clock);
    @(posedge clock) nmiPin <= 1'b1;
    wait_load(SIVC_K_USER);
    @(posedge clock) #1 chk("disarm", userLevelEventArmed, 0);
    vread(2'h2, 16'h0002);
    chk("rearm", userLevelEventArmed, 1);
    $display("test acceptance done");
    end_sim();
  end
endmodule
